// [bench/sar_adc_chk.sv]
/*
 Concurrent checks on the ports of the converter sequencer.
 Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sar_adc_chk
	import sar_adc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic [7:0] rdata,
	input wire logic       sleep,
	input wire logic       event_trigger,
	input wire logic       irq,
	input wire logic       timer_clear,
	input wire logic       powered,
	input wire logic       converting
);
	logic [2:0] clk_sel;
	wire        ctrl0_wr = wr_en && addr == ADDR_CTRL_ZERO;
	wire        divided  = clk_sel[1:0] != CLK_RC_LOW;
	wire        ready    = powered && !converting && !sleep && divided;

	// Shadow of the clock-select field; the RC source starts late on purpose.
	always_ff @(posedge clk)
		if (rst)
			clk_sel <= 3'h0;
		else if (wr_en && addr == ADDR_CTRL_ONE)
			clk_sel <= wdata[6:4];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Requests that must open a conversion on the next edge.
	sequence s_go_write;
		ready && ctrl0_wr && wdata[1:0] == 2'h3;
	endsequence
	sequence s_trigger;
		ready && event_trigger && !ctrl0_wr;
	endsequence

	a_go_starts: assert property (s_go_write |=> converting)
		else $error("go write did not start a conversion");
	a_trigger_starts: assert property (s_trigger |=> converting)
		else $error("trigger did not start a conversion");
	a_timer_clear_pulse: assert property (event_trigger |=> timer_clear)
		else $error("timer clear missing after trigger");
	a_abort_stops: assert property
		(converting && ctrl0_wr && wdata[1:0] == 2'h1 |=> !converting)
		else $error("go clear did not stop the conversion");
	a_sleep_aborts: assert property
		(converting && sleep && divided |-> ##[1:2] (!converting && !powered))
		else $error("sleep on divided clock did not abort");
	a_irq_mask_off: assert property
		(wr_en && addr == ADDR_IRQ_EN && !wdata[0] |=> !irq)
		else $error("irq stayed high with enable cleared");
	a_irq_fall_cause: assert property
		($fell(irq) |-> $past(wr_en)
			&& ($past(addr) == ADDR_FLAG || $past(addr) == ADDR_IRQ_EN))
		else $error("irq fell without a software write");
	a_conv_length: assert property
		($rose(converting) && clk_sel == CLK_DIV2 |-> ##[20:28] !converting)
		else $error("half-rate conversion too long");
	a_reset_clears: assert property
		($fell(rst) |-> !converting && !powered && !irq && rdata == 8'h00)
		else $error("outputs not cleared by reset");
endmodule : sar_adc_chk

bind sar_adc_sequencer sar_adc_chk chk (.clk, .rst, .addr, .wdata, .wr_en,
	.rdata, .sleep, .event_trigger, .irq, .timer_clear, .powered, .converting);

// [bench/tb_top.sv]
/*
 Self-checking bench of the converter sequencer: registers, every clock
 source, result formats, abort, sleep, trigger and reset.
 Assumes the register map and timing of the design package.
*/
`timescale 1ns/1ps
module tb_top
	import sar_adc_pkg::*;
;
	logic        clk           = 1'b0;
	logic        rst           = 1'b1;
	logic  [2:0] addr          = 3'h0;
	logic  [7:0] wdata         = 8'h00;
	logic        wr_en         = 1'b0;
	logic        rd_en         = 1'b0;
	logic        comparator    = 1'b0;
	logic        rc_tick       = 1'b0;
	logic        instr_tick    = 1'b0;
	logic        sleep         = 1'b0;
	logic        event_trigger = 1'b0;
	int          wake_count    = 0;
	logic  [9:0] target        = 10'h000;
	logic  [7:0] rdata;
	logic  [9:0] trial_code;
	logic  [4:0] channel_select;
	logic  [1:0] pos_ref;
	logic        irq, wake, timer_clear, powered, converting, neg_ref;
	int          fail_count    = 0;
	int          tests_run     = 0;
	int          cyc           = 0;

	sar_adc_sequencer dut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
		.comparator, .rc_tick, .instr_tick, .sleep, .event_trigger, .irq,
		.wake, .timer_clear, .powered, .converting, .trial_code,
		.channel_select, .pos_ref, .neg_ref);

	always #25 clk = ~clk;

	// Ticks at unrelated rates; the input sits half a step above target,
	// so a correct search lands exactly on target.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rc_tick <= (cyc % 3 == 0);
		instr_tick <= (cyc % 5 == 1);
		comparator <= (trial_code <= target);
		if (wake === 1'b1)
			wake_count <= wake_count + 1;
		if (cyc == 10000)
		begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test;
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [9:0] got, input logic [9:0] exp,
		input string what);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd_check(input logic [2:0] a, input logic [7:0] exp,
		input string what);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 check(rdata, exp, what);
	endtask : rd_check

	task automatic regs_zero;
		for (int a = 0; a < 8; a++)
			rd_check(3'(a), 8'h00, "reset value");
	endtask : regs_zero

	task automatic results(input logic [15:0] exp);
		rd_check(ADDR_RES_HIGH, exp[15:8], "result high");
		rd_check(ADDR_RES_LOW, exp[7:0], "result low");
	endtask : results

	function automatic logic [15:0] fmt(input logic [9:0] r, input logic right);
		fmt = right ? {6'h00, r} : {r, 6'h00};
	endfunction : fmt

	// Counts system cycles, or RC ticks for the RC source, while converting is high.
	task automatic run(input logic rc, output int ticks);
		int n;
		ticks = 0;
		n = 0;
		while (converting !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n++;
		end
		while (converting === 1'b1 && n < 3000)
		begin
			@(posedge clk);
			#1 n++;
			ticks += rc ? int'(rc_tick) : 1;
		end
	endtask : run

	initial
	begin
		logic [15:0] prev;
		logic  [7:0] d;
		logic        just;
		logic        en;
		int          t;
		int          e;
		int          w;
		void'($urandom(32'h7f0e));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		regs_zero();
		d = {5'h00, 3'($urandom)};
		wr(ADDR_CTRL_ONE, d);
		rd_check(ADDR_CTRL_ONE, d, "control one");
		check({neg_ref, pos_ref}, d[2:0], "references");
		d = {1'b0, 5'($urandom), 2'b01};
		wr(ADDR_CTRL_ZERO, d);
		check(channel_select, d[6:2], "channel");
		// Every select code, corner codes at the ends of the range.
		for (int s = 0; s < 8; s++)
		begin
			just = 1'($urandom);
			en = 1'($urandom);
			target = (s == 0) ? 10'h3ff : (s == 1) ? 10'h000 : 10'($urandom);
			e = (s % 4 == 3) ? 23 : 23 << (2 * (s % 4) + s / 4);
			wr(ADDR_IRQ_EN, {7'h00, en});
			wr(ADDR_CTRL_ONE, {just, 3'(s), 4'h0});
			wr(ADDR_CTRL_ZERO, 8'h03);
			check(converting, 10'(s % 4 != 3), "start delay");
			check(channel_select, 5'h00, "channel zero");
			run(s % 4 == 3, t);
			check(10'(t >= e - 3 && t <= e + 3), 10'h1, "length");
			rd_check(ADDR_CTRL_ZERO, 8'h01, "go cleared");
			rd_check(ADDR_FLAG, 8'h01, "done flag");
			prev = fmt(target, just);
			results(prev);
			check(irq, en, "irq");
			rd_check(ADDR_FLAG, 8'h01, "flag holds");
			wr(ADDR_FLAG, 8'h00);
			check(irq, 1'b0, "irq cleared");
		end
		// Abort on divide by 64 after two resolved bits; results hold first.
		wr(ADDR_CTRL_ONE, 8'he0);
		target = 10'($urandom);
		wr(ADDR_CTRL_ZERO, 8'h03);
		repeat (232) @(posedge clk);
		results(prev);
		wr(ADDR_CTRL_ZERO, 8'h01);
		results(fmt({target[9:8], {8{target[8]}}}, 1'b1));
		repeat (40) @(posedge clk);
		wr(ADDR_CTRL_ONE, 8'h80);
		wr(ADDR_CTRL_ZERO, 8'h02);
		check(converting, 1'b0, "go without enable");
		// Enable first, let the input settle, and only then set go.
		wr(ADDR_CTRL_ZERO, 8'h01);
		repeat (4) @(posedge clk);
		wr(ADDR_CTRL_ZERO, 8'h03);
		repeat (5) @(posedge clk);
		sleep <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check({converting, powered}, 2'b00, "sleep abort");
		rd_check(ADDR_CTRL_ZERO, 8'h01, "enable kept");
		@(posedge clk);
		sleep <= 1'b0;
		repeat (3) @(posedge clk);
		#1 check(powered, 1'b1, "powered again");
		// RC conversion in sleep, irq enabled then disabled.
		for (e = 1; e >= 0; e--)
		begin
			wr(ADDR_IRQ_EN, 8'(e));
			wr(ADDR_CTRL_ONE, 8'h30);
			wr(ADDR_CTRL_ZERO, 8'h03);
			@(posedge clk);
			sleep <= 1'b1;
			w = wake_count;
			run(1'b1, t);
			repeat (2) @(posedge clk);
			#1 check(10'(wake_count - w), 10'(e), "wake");
			check(powered, 10'(e), "powered after sleep");
			check(10'(t >= 20), 10'h1, "ran in sleep");
			rd_check(ADDR_CTRL_ZERO, 8'h01, "enable kept");
			@(posedge clk);
			sleep <= 1'b0;
			wr(ADDR_FLAG, 8'h00);
		end
		wr(ADDR_CTRL_ONE, 8'h00);
		target = 10'($urandom);
		@(posedge clk);
		event_trigger <= 1'b1;
		@(posedge clk);
		event_trigger <= 1'b0;
		#1 check({timer_clear, converting}, 2'b11, "trigger");
		run(1'b0, t);
		results(fmt(target, 1'b0));
		// Reset in mid conversion.
		wr(ADDR_CTRL_ONE, 8'h60);
		wr(ADDR_CTRL_ZERO, 8'h03);
		repeat (50) @(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		regs_zero();
		check(converting, 1'b0, "reset stops");
		finish_test();
	end
endmodule : tb_top

// [src/sar_adc_pkg.sv]
/*
 Shared constants, types and helper functions of the converter sequencer:
 register indices, field positions, reset values, clock-select codes and
 conversion timing. Assumes an 8-bit register port with a 3-bit index.
*/
package sar_adc_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] ADDR_CTRL_ZERO = 3'h0;
	localparam logic [2:0] ADDR_CTRL_ONE  = 3'h1;
	localparam logic [2:0] ADDR_RES_HIGH  = 3'h2;
	localparam logic [2:0] ADDR_RES_LOW   = 3'h3;
	localparam logic [2:0] ADDR_FLAG      = 3'h4;
	localparam logic [2:0] ADDR_IRQ_EN    = 3'h5;

	// Field positions.
	localparam int ENABLE_BIT  = 0;
	localparam int GO_BIT      = 1;
	localparam int CHAN_LSB    = 2;
	localparam int CHAN_MSB    = 6;
	localparam int PREF_LSB    = 0;
	localparam int PREF_MSB    = 1;
	localparam int NREF_BIT    = 2;
	localparam int CLKSEL_LSB  = 4;
	localparam int CLKSEL_MSB  = 6;
	localparam int JUSTIFY_BIT = 7;
	localparam int DONE_BIT    = 0;
	localparam int IRQ_EN_BIT  = 0;

	// Values after reset.
	localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
	localparam logic [7:0] CTRL_ONE_RESET  = 8'h00;
	localparam logic [7:0] RESULT_RESET    = 8'h00;

	// Conversion timing in half bit periods: 11.5 periods in all.
	localparam logic [4:0] HALVES_PER_CONV = 5'd23;
	localparam logic [4:0] FIRST_RESOLVE   = 5'd4;
	localparam logic [4:0] LAST_RESOLVE    = 5'd22;
	localparam logic [9:0] FIRST_TRIAL     = 10'h200;
	localparam logic [3:0] RESULT_BITS     = 4'd10;

	// Clock-select codes; the two low bits 11 pick the RC oscillator.
	localparam logic [2:0] CLK_DIV2  = 3'h0;
	localparam logic [2:0] CLK_DIV4  = 3'h4;
	localparam logic [2:0] CLK_DIV8  = 3'h1;
	localparam logic [2:0] CLK_DIV16 = 3'h5;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h6;
	localparam logic [1:0] CLK_RC_LOW = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DELAY = 3'b010,
		ST_CONV  = 3'b100
	} seq_state_t;

	// System clocks in one half bit period for a divided source.
	function automatic logic [5:0] half_period_cycles(input logic [2:0] sel);
		case (sel)
			CLK_DIV2:  half_period_cycles = 6'h01;
			CLK_DIV4:  half_period_cycles = 6'h02;
			CLK_DIV8:  half_period_cycles = 6'h04;
			CLK_DIV16: half_period_cycles = 6'h08;
			CLK_DIV32: half_period_cycles = 6'h10;
			CLK_DIV64: half_period_cycles = 6'h20;
			default:   half_period_cycles = 6'h01;
		endcase
	endfunction : half_period_cycles

	function automatic logic is_rc_source(input logic [2:0] sel);
		is_rc_source = (sel[1:0] == CLK_RC_LOW);
	endfunction : is_rc_source

endpackage : sar_adc_pkg

// [src/sar_adc_sequencer.sv]
/*
 Control sequencer of a 10-bit successive-approximation converter:
 registers, start, abort, completion, result formatting and sleep.
 Assumes a synchronous register port, a comparator input that is valid
 whenever a bit is resolved, and one-cycle pulses for the RC oscillator,
 the instruction cycle and the compare-unit trigger.
*/
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sar_adc_sequencer
	import sar_adc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       comparator,
	input  wire logic       rc_tick,
	input  wire logic       instr_tick,
	input  wire logic       sleep,
	input  wire logic       event_trigger,
	output logic            irq,
	output logic            wake,
	output logic            timer_clear,
	output logic            powered,
	output logic            converting,
	output logic      [9:0] trial_code,
	output logic      [4:0] channel_select,
	output logic      [1:0] pos_ref,
	output logic            neg_ref
);

	// Register contents.
	logic             converter_enable;
	logic             go;
	logic             result_justify_select;
	logic       [2:0] conv_clock_select;
	logic             conv_done_flag;
	logic             conv_irq_enable;
	logic       [7:0] result_high_byte;
	logic       [7:0] result_low_byte;

	// Sequencer state.
	seq_state_t       state;
	logic       [4:0] halves;
	logic       [9:0] sar;
	logic       [9:0] trial;
	logic       [3:0] resolved;
	logic             power_down;

	// Next values.
	seq_state_t       next_state;
	logic       [4:0] next_halves;
	logic       [9:0] next_sar;
	logic       [9:0] next_trial;
	logic       [3:0] next_resolved;
	logic             next_power_down;
	logic             next_go;
	logic             next_enable;
	logic             next_flag;
	logic             next_irq_enable;
	logic       [7:0] next_high;
	logic       [7:0] next_low;

	logic             half_tick;

	// Fills every unresolved bit with the value of the last one resolved.
	function automatic logic [9:0] fill_partial(input logic [9:0] value,
		input logic [3:0] count);
		logic [9:0] keep;
		logic       last;
		keep = ~(10'h3ff >> count);
		last = (count != 4'h0) && value[RESULT_BITS - count];
		fill_partial = (value & keep) | (~keep & {10{last}});
	endfunction : fill_partial

	// Register decode.
	wire wr_ctrl0  = wr_en && (addr == ADDR_CTRL_ZERO);
	wire wr_ctrl1  = wr_en && (addr == ADDR_CTRL_ONE);
	wire wr_high   = wr_en && (addr == ADDR_RES_HIGH);
	wire wr_low    = wr_en && (addr == ADDR_RES_LOW);
	wire wr_flag   = wr_en && (addr == ADDR_FLAG);
	wire wr_irq_en = wr_en && (addr == ADDR_IRQ_EN);

	// Sequencing conditions.
	wire busy       = (state != ST_IDLE);
	wire rc_sel     = is_rc_source(conv_clock_select);
	wire sleep_stop = sleep && !rc_sel;
	wire turn_off   = wr_ctrl0 && !wdata[ENABLE_BIT] && busy;
	wire sleep_abort = sleep_stop && busy;
	wire sw_abort   = wr_ctrl0 && !wdata[GO_BIT] && busy && !turn_off;
	wire sw_start   = wr_ctrl0 && wdata[GO_BIT] && wdata[ENABLE_BIT];
	wire hw_start   = event_trigger && converter_enable && !wr_ctrl0;
	wire start      = !busy && !sleep_stop && !power_down
		&& (sw_start || hw_start);
	wire hard_stop  = turn_off || sleep_abort;

	// Half-period bookkeeping: bits resolve on even halves 4..22.
	wire [4:0] halves_inc = halves + 5'd1;
	wire tick_conv  = (state == ST_CONV) && half_tick;
	wire resolve    = tick_conv && !halves_inc[0]
		&& (halves_inc >= FIRST_RESOLVE) && (halves_inc <= LAST_RESOLVE);
	wire finish     = tick_conv && (halves_inc == HALVES_PER_CONV)
		&& !hard_stop && !sw_abort;

	// Keep the trial bit if the input is above it, then try the next.
	wire [9:0] cmp_bit   = comparator ? trial : 10'h000;
	wire [9:0] resolved_sar = (sar & ~trial) | cmp_bit | (trial >> 1);

	// Result loading and its formatted bytes.
	wire load_part = sw_abort;
	wire load      = finish || load_part;
	wire [9:0] result_value = finish ? sar : fill_partial(sar, resolved);
	wire [7:0] fmt_high = result_justify_select
		? {6'h00, result_value[9:8]} : result_value[9:2];
	wire [7:0] fmt_low  = result_justify_select
		? result_value[7:0] : {result_value[1:0], 6'h00};

	// Read multiplexer; unmapped indices read as zero.
	wire [7:0] ctrl0_view = {1'b0, channel_select, go, converter_enable};
	wire [7:0] ctrl1_view = {result_justify_select, conv_clock_select,
		1'b0, neg_ref, pos_ref};
	wire [7:0] read_mux =
		(addr == ADDR_CTRL_ZERO) ? ctrl0_view :
		(addr == ADDR_CTRL_ONE)  ? ctrl1_view :
		(addr == ADDR_RES_HIGH)  ? result_high_byte :
		(addr == ADDR_RES_LOW)   ? result_low_byte :
		(addr == ADDR_FLAG)      ? {7'h00, conv_done_flag} :
		(addr == ADDR_IRQ_EN)    ? {7'h00, conv_irq_enable} : 8'h00;

	// Sequencer and register next values.
	always_comb
	begin
		next_state      = state;
		next_halves     = halves;
		next_sar        = sar;
		next_trial      = trial;
		next_resolved   = resolved;
		next_go         = go;
		next_enable     = wr_ctrl0 ? wdata[ENABLE_BIT] : converter_enable;
		next_power_down = power_down;
		next_irq_enable = wr_irq_en ? wdata[IRQ_EN_BIT] : conv_irq_enable;
		next_high       = wr_high ? wdata : result_high_byte;
		next_low        = wr_low ? wdata : result_low_byte;
		// A write of the flag register may only change the flag by value.
		next_flag       = wr_flag ? wdata[DONE_BIT] : conv_done_flag;
		if (wr_ctrl0 && !busy)
			next_go = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (start)
				begin
					next_go       = 1'b1;
					next_halves   = 5'd0;
					next_sar      = FIRST_TRIAL;
					next_trial    = FIRST_TRIAL;
					next_resolved = 4'h0;
					if (rc_sel)
						next_state = ST_DELAY;
					else
						next_state = ST_CONV;
				end
			end
			ST_DELAY:
			begin
				// The extra instruction lets a sleep instruction go first.
				if (hard_stop || sw_abort)
				begin
					next_go    = 1'b0;
					next_state = ST_IDLE;
				end
				else if (instr_tick)
					next_state = ST_CONV;
			end
			ST_CONV:
			begin
				if (hard_stop || sw_abort || finish)
				begin
					next_go    = 1'b0;
					next_state = ST_IDLE;
				end
				else if (tick_conv)
				begin
					next_halves = halves_inc;
					if (resolve)
					begin
						next_sar      = resolved_sar;
						next_trial    = trial >> 1;
						next_resolved = resolved + 4'h1;
					end
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_go    = 1'b0;
			end
		endcase
		// Completion wins over a software clear in the same cycle.
		if (finish)
			next_flag = 1'b1;
		if (load)
		begin
			next_high = fmt_high;
			next_low  = fmt_low;
		end
		// Power-down holds the enable bit but idles the analog side.
		if (sleep_abort || (sleep_stop && converter_enable))
			next_power_down = 1'b1;
		else if (finish && sleep && !conv_irq_enable)
			next_power_down = 1'b1;
		else if (!sleep)
			next_power_down = 1'b0;
	end

	// Sequencer, flag and result flops; reset stops any conversion.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state      <= ST_IDLE;
			halves     <= 5'd0;
			sar        <= 10'h000;
			trial      <= 10'h000;
			resolved   <= 4'h0;
			power_down <= 1'b0;
			conv_done_flag   <= 1'b0;
			conv_irq_enable  <= 1'b0;
			result_high_byte <= RESULT_RESET;
			result_low_byte  <= RESULT_RESET;
		end
		else
		begin
			state      <= next_state;
			halves     <= next_halves;
			sar        <= next_sar;
			trial      <= next_trial;
			resolved   <= next_resolved;
			power_down <= next_power_down;
			conv_done_flag   <= next_flag;
			conv_irq_enable  <= next_irq_enable;
			result_high_byte <= next_high;
			result_low_byte  <= next_low;
		end
	end

	// Control registers.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			converter_enable      <= CTRL_ZERO_RESET[ENABLE_BIT];
			go                    <= CTRL_ZERO_RESET[GO_BIT];
			channel_select        <= CTRL_ZERO_RESET[CHAN_MSB:CHAN_LSB];
			result_justify_select <= CTRL_ONE_RESET[JUSTIFY_BIT];
			conv_clock_select     <= CTRL_ONE_RESET[CLKSEL_MSB:CLKSEL_LSB];
			neg_ref               <= CTRL_ONE_RESET[NREF_BIT];
			pos_ref               <= CTRL_ONE_RESET[PREF_MSB:PREF_LSB];
		end
		else
		begin
			converter_enable <= next_enable;
			go               <= next_go;
			if (wr_ctrl0)
				channel_select <= wdata[CHAN_MSB:CHAN_LSB];
			if (wr_ctrl1)
			begin
				result_justify_select <= wdata[JUSTIFY_BIT];
				conv_clock_select     <= wdata[CLKSEL_MSB:CLKSEL_LSB];
				neg_ref               <= wdata[NREF_BIT];
				pos_ref               <= wdata[PREF_MSB:PREF_LSB];
			end
		end
	end

	// Outputs, each from a flop, aligned with the registers they mirror.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata       <= 8'h00;
			irq         <= 1'b0;
			wake        <= 1'b0;
			timer_clear <= 1'b0;
			powered     <= 1'b0;
			converting  <= 1'b0;
			trial_code  <= 10'h000;
		end
		else
		begin
			rdata       <= rd_en ? read_mux : 8'h00;
			irq         <= next_flag && next_irq_enable;
			wake        <= finish && sleep && conv_irq_enable;
			timer_clear <= event_trigger;
			powered     <= next_enable && !next_power_down;
			converting  <= (next_state == ST_CONV);
			trial_code  <= next_sar;
		end
	end

	sar_bit_clock u_bit_clock (
		.clk          (clk),
		.rst          (rst),
		.clock_select (conv_clock_select),
		.run          (state == ST_CONV),
		.rc_tick      (rc_tick),
		.half_tick    (half_tick)
	);

endmodule : sar_adc_sequencer

// [src/sar_bit_clock.sv]
/*
 Bit-period timebase of the converter: one pulse per half bit period,
 either from a divided system clock or from the RC oscillator ticks.
 Assumes rc_tick is a one-cycle pulse, synchronous to clk, marking each
 half period of the RC oscillator.
*/
`timescale 1ns/1ps
module sar_bit_clock
	import sar_adc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] clock_select,
	input  wire logic       run,
	input  wire logic       rc_tick,
	output logic            half_tick
);

	logic [5:0] count;

	wire       rc_mode = is_rc_source(clock_select);
	wire [5:0] limit   = half_period_cycles(clock_select);
	wire [5:0] count_inc = count + 6'h01;
	wire       wrap    = (count_inc >= limit);

	// The divider restarts with every conversion, so a change of the
	// system clock rate simply stretches or shrinks each period.
	always_ff @(posedge clk)
	begin
		if (rst || !run)
			count <= 6'h00;
		else if (rc_mode || wrap)
			count <= 6'h00;
		else
			count <= count_inc;
	end

	// The RC source ignores the divider entirely.
	always_ff @(posedge clk)
	begin
		if (rst || !run)
			half_tick <= 1'b0;
		else if (rc_mode)
			half_tick <= rc_tick;
		else
			half_tick <= wrap;
	end

endmodule : sar_bit_clock
